/* design/dams_pkg.sv */
// package: register offsets, field positions, reset values, carriers
package dams_pkg;
    // ******
    // register indices on the access port
    // ******
    localparam logic [7:0] SHADOW_CONTROL_IDX   = 8'hB5;
    localparam logic [7:0] SEG_ENABLE_LO_IDX    = 8'hB6;
    localparam logic [7:0] SEG_ENABLE_HI_IDX    = 8'hB7;
    localparam logic [7:0] WINDOW_SELECT_IDX    = 8'hB8;
    localparam logic [7:0] SPLIT_ADDRESS_IDX    = 8'hB9;
    localparam logic [7:0] EXP_PAGE_BASE_IDX    = 8'hC0;
    localparam logic [7:0] BAD_BLOCK_BASE_IDX   = 8'hC8;
    localparam logic [7:0] GOOD_SEGMENT_IDX     = 8'hD0;
    localparam logic [7:0] RECOVERY_BASE_IDX    = 8'hD4;
    localparam logic [7:0] BANK_CONFIG_IDX      = 8'hD9;
    localparam logic [7:0] SPLIT_CONTROL_IDX    = 8'hE1;
    // ******
    // field positions
    // ******
    localparam int PARITY_DISABLE_BIT = 0;
    localparam int ROM_ENABLE_BIT     = 1;
    localparam int BOUNDARY_512_BIT   = 2;
    localparam int SPLIT_DISABLE_BIT  = 3;
    localparam int EXP_ENABLE_BIT     = 7;
    localparam int PORT_PAR_EN_BIT    = 2;
    localparam int PORT_CHK_EN_BIT    = 3;
    localparam int PORT_PAR_ERR_BIT   = 7;
    // ******
    // reset values
    // ******
    localparam logic [7:0] SPLIT_CONTROL_RST  = 8'h02;
    localparam logic [7:0] SHADOW_CONTROL_RST = 8'h00;
    localparam logic [7:0] WINDOW_SELECT_RST  = 8'h04;
    localparam logic [7:0] SPLIT_ADDRESS_RST  = 8'h01;
    // ******
    // address map constants (byte addresses, 24-bit space)
    // ******
    localparam logic [23:0] ADDR_512K   = 24'h080000;
    localparam logic [23:0] ADDR_640K   = 24'h0A0000;
    localparam logic [23:0] ADDR_896K   = 24'h0E0000;
    localparam logic [23:0] ADDR_1M     = 24'h100000;
    localparam logic [23:0] SHADOW_LO   = 24'h0A0000;
    localparam logic [23:0] SHADOW_HI   = 24'h0DFFFF;
    localparam logic [23:0] WPROT_LO    = 24'h0C0000;
    localparam logic [23:0] ROM_LO      = 24'h0E0000;
    localparam logic [23:0] WINDOW_C0   = 24'h0C0000;
    localparam int          NUM_BAD     = 4;
    localparam int          NUM_PAGES   = 4;
    localparam int          NUM_SEGS    = 16;
    // ******
    // carriers
    // ******
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        mem_io;
        logic [30:0] addr;
    } dams_req_s;
    typedef struct packed {
        logic        mem_io;
        logic        arb_grant;
        logic [3:0]  arb_level;
        logic        data_ctl;
        logic [30:2] addr;
    } dams_capture_s;
endpackage

/* design/dams_regfile.sv */
// small register memory for page map and bad block entries
`timescale 1ns/100ps
module dams_regfile
    import dams_pkg::*;
#(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input  wire logic                     i_clock,
    input  wire logic                     i_rst_n,
    input  wire logic                     i_wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] i_wr_idx,
    input  wire logic [WIDTH-1:0]         i_wr_data,
    output logic      [DEPTH*WIDTH-1:0]   o_all
);
    // ******
    // storage
    // ******
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [WIDTH-1:0] nxt_mem [DEPTH];

    // per-entry next value; all entries visible in parallel
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_ent
            always_comb begin
                nxt_mem[g] = mem_ff[g];
                if (i_wr_en && (int'(i_wr_idx) == g)) begin
                    nxt_mem[g] = i_wr_data;
                end
            end
            always_ff @(posedge i_clock) begin
                if (!i_rst_n) begin
                    mem_ff[g] <= '0;
                end else begin
                    mem_ff[g] <= nxt_mem[g];
                end
            end
            assign o_all[g*WIDTH +: WIDTH] = mem_ff[g];
        end
    endgenerate
endmodule

/* design/dams_recovery.sv */
// capture of the last command's address and control on channel error
`timescale 1ns/100ps
module dams_recovery
    import dams_pkg::*;
(
    input  wire logic          i_clock,
    input  wire logic          i_rst_n,
    input  wire logic          i_cmd_strobe,
    input  wire dams_capture_s i_cmd,
    input  wire logic          i_channel_error_n,
    output logic               o_held,
    output dams_capture_s      o_capture
);
    // ******
    // capture state
    // ******
    dams_capture_s last_ff;
    dams_capture_s nxt_last;
    dams_capture_s cap_ff;
    dams_capture_s nxt_cap;
    logic          held_ff;
    logic          nxt_held;

    // keep the previous command; freeze on first error until error clears
    always_comb begin
        nxt_last = last_ff;
        nxt_cap  = cap_ff;
        nxt_held = held_ff;
        if (!i_channel_error_n && !held_ff) begin
            nxt_cap  = last_ff;
            nxt_held = 1'b1;
        end else if (i_channel_error_n) begin
            nxt_held = 1'b0;
        end
        if (i_cmd_strobe && i_channel_error_n) begin
            nxt_last = i_cmd;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            last_ff <= '0;
            cap_ff  <= '0;
            held_ff <= 1'b0;
        end else begin
            last_ff <= nxt_last;
            cap_ff  <= nxt_cap;
            held_ff <= nxt_held;
        end
    end

    assign o_held    = held_ff;
    assign o_capture = cap_ff;
endmodule

/* design/dams_top.sv */
// address map, shadow, expanded window, bad block and parity control
// ******
// Overview of operation
// - split relocates hidden RAM above 1MB
// - single bank works page mode only
// - rom enable zero stops board rom select
// - split control bit 3 disables split
// - split boundary select picks 640K or 512K
// - relocated block at megabyte 1 to 15
// - window page replaces A14 to A22
// - window base D0000 or C0000..CC000
// - page maps in the lower 8MB, A22 copying A21
// - four bad 16KB blocks remapped in segment
// - shadow A0000-DFFFF per 16K, else unusable outside the window
// - shadow control bits 4,5 enable shadow
// - shadow control bits 6,7 write protect
// - latch address and control on channel error
// - parity disable bit resets to zero
// - parity error sets port bit 7, NMI
// - banks 32 plus 4 parity, 256K/1M
// - interleave only matching pairs, bank2 page
// ******
`timescale 1ns/100ps
module dams_top
    import dams_pkg::*;
#(
    parameter int ADDR_W = 24
) (
    input  wire logic          i_clock,
    input  wire logic          i_rst_n,
    input  wire logic          i_reg_wr,
    input  wire logic          i_reg_rd,
    input  wire logic [7:0]    i_reg_idx,
    input  wire logic [7:0]    i_reg_wdata,
    output logic      [7:0]    o_reg_rdata,
    input  wire dams_req_s     i_req,
    input  wire logic          i_arb_grant_phase,
    input  wire logic [3:0]    i_arbitration_level_lines,
    input  wire logic          i_data_ctl,
    input  wire logic          i_channel_error_n,
    input  wire logic          i_external_mapper_select_n,
    input  wire logic          i_parity_error,
    input  wire logic          i_port61_wr,
    input  wire logic [7:0]    i_port61_wdata,
    output logic      [7:0]    o_port61_rdata,
    output logic               o_nmi,
    output logic [ADDR_W-1:0]  o_phys_addr,
    output logic               o_ram_select,
    output logic               o_ram_write_en,
    output logic               o_bios_rom_select_n,
    output logic [1:0]         o_bank_mode
);
    // ******
    // configuration registers
    // ******
    logic [7:0] split_control_ff, nxt_split_control;
    logic [7:0] shadow_control_ff, nxt_shadow_control;
    logic [7:0] seg_lo_ff, nxt_seg_lo;
    logic [7:0] seg_hi_ff, nxt_seg_hi;
    logic [7:0] window_sel_ff, nxt_window_sel;
    logic [3:0] split_addr_ff, nxt_split_addr;
    logic [5:0] good_seg_ff, nxt_good_seg;
    logic [7:0] bank_cfg_ff, nxt_bank_cfg;
    logic [7:0] port61_ff, nxt_port61;
    logic       nmi_ff, nxt_nmi;
    logic [7:0] rdata_ff, nxt_rdata;

    // sub-bits of the configuration
    logic parity_off, rom_en, bound_512, split_off, exp_en;
    assign parity_off = split_control_ff[PARITY_DISABLE_BIT];
    assign rom_en     = split_control_ff[ROM_ENABLE_BIT];
    assign bound_512  = split_control_ff[BOUNDARY_512_BIT];
    assign split_off  = split_control_ff[SPLIT_DISABLE_BIT];
    // external mapper pin low hands translation to the outside
    assign exp_en = window_sel_ff[EXP_ENABLE_BIT] &&
                    i_external_mapper_select_n;

    // ******
    // page map and bad block tables
    // ******
    logic        pg_wr, bb_wr;
    logic [1:0]  tbl_idx;
    logic [35:0] page_all;
    logic [39:0] bad_all;
    assign pg_wr   = i_reg_wr && (i_reg_idx[7:3] == EXP_PAGE_BASE_IDX[7:3])
                     && !i_reg_idx[2];
    assign bb_wr   = i_reg_wr && (i_reg_idx[7:3] == BAD_BLOCK_BASE_IDX[7:3])
                     && !i_reg_idx[2];
    assign tbl_idx = i_reg_idx[1:0];

    // page entries hold A22..A14; data byte with bit 7 repeated on top gives 9
    dams_regfile #(.WIDTH(9), .DEPTH(NUM_PAGES)) u_pages (
        .i_clock   (i_clock),
        .i_rst_n   (i_rst_n),
        .i_wr_en   (pg_wr),
        .i_wr_idx  (tbl_idx),
        .i_wr_data ({i_reg_wdata[7], i_reg_wdata}),
        .o_all     (page_all)
    );
    // bad block entries: valid, zero, block A21..A14 (low byte); index is slot
    dams_regfile #(.WIDTH(10), .DEPTH(NUM_BAD)) u_bad (
        .i_clock   (i_clock),
        .i_rst_n   (i_rst_n),
        .i_wr_en   (bb_wr),
        .i_wr_idx  (tbl_idx),
        .i_wr_data ({i_reg_wdata[7], 1'b0, i_reg_wdata}),
        .o_all     (bad_all)
    );

    // ******
    // channel error recovery
    // ******
    dams_capture_s cmd_now, cap;
    logic          cap_held;
    assign cmd_now = '{mem_io: i_req.mem_io, arb_grant: i_arb_grant_phase,
                       arb_level: i_arbitration_level_lines,
                       data_ctl: i_data_ctl, addr: i_req.addr[30:2]};
    dams_recovery u_recovery (
        .i_clock           (i_clock),
        .i_rst_n           (i_rst_n),
        .i_cmd_strobe      (i_req.valid),
        .i_cmd             (cmd_now),
        .i_channel_error_n (i_channel_error_n),
        .o_held            (cap_held),
        .o_capture         (cap)
    );

    // ******
    // register writes, port 61 and parity handling
    // ******
    logic par_enabled;
    // port bits 2,3 must be zero and parity check not disabled
    assign par_enabled = !parity_off && !port61_ff[PORT_PAR_EN_BIT] &&
                         !port61_ff[PORT_CHK_EN_BIT];
    always_comb begin
        nxt_split_control  = split_control_ff;
        nxt_shadow_control = shadow_control_ff;
        nxt_seg_lo         = seg_lo_ff;
        nxt_seg_hi         = seg_hi_ff;
        nxt_window_sel     = window_sel_ff;
        nxt_split_addr     = split_addr_ff;
        nxt_good_seg       = good_seg_ff;
        nxt_bank_cfg       = bank_cfg_ff;
        nxt_port61         = port61_ff;
        nxt_nmi            = nmi_ff;
        if (i_reg_wr) begin
            case (i_reg_idx)
                SPLIT_CONTROL_IDX:  nxt_split_control  = i_reg_wdata;
                SHADOW_CONTROL_IDX: nxt_shadow_control = i_reg_wdata;
                SEG_ENABLE_LO_IDX:  nxt_seg_lo         = i_reg_wdata;
                SEG_ENABLE_HI_IDX:  nxt_seg_hi         = i_reg_wdata;
                WINDOW_SELECT_IDX:  nxt_window_sel     = i_reg_wdata;
                SPLIT_ADDRESS_IDX:  nxt_split_addr     = i_reg_wdata[3:0];
                GOOD_SEGMENT_IDX:   nxt_good_seg       = i_reg_wdata[5:0];
                BANK_CONFIG_IDX:    nxt_bank_cfg       = i_reg_wdata;
                default: ;
            endcase
        end
        if (i_port61_wr) begin
            nxt_port61[6:0] = i_port61_wdata[6:0];
        end
        // writing a one to a clear bit drops the latched error
        if ((i_reg_wr && (i_reg_idx == SPLIT_CONTROL_IDX) &&
             i_reg_wdata[PARITY_DISABLE_BIT]) ||
            (i_port61_wr && i_port61_wdata[PORT_PAR_EN_BIT])) begin
            nxt_port61[PORT_PAR_ERR_BIT] = 1'b0;
            nxt_nmi = 1'b0;
        end
        // set wins over the clear in the same cycle
        if (i_parity_error && par_enabled) begin
            nxt_port61[PORT_PAR_ERR_BIT] = 1'b1;
            nxt_nmi = 1'b1;
        end
    end

    // ******
    // read mux; table entries and capture words are readable
    // ******
    always_comb begin
        nxt_rdata = rdata_ff;
        if (i_reg_rd) begin
            nxt_rdata = 8'h00;
            case (i_reg_idx)
                SPLIT_CONTROL_IDX:  nxt_rdata = split_control_ff;
                SHADOW_CONTROL_IDX: nxt_rdata = shadow_control_ff;
                SEG_ENABLE_LO_IDX:  nxt_rdata = seg_lo_ff;
                SEG_ENABLE_HI_IDX:  nxt_rdata = seg_hi_ff;
                WINDOW_SELECT_IDX:  nxt_rdata = window_sel_ff;
                SPLIT_ADDRESS_IDX:  nxt_rdata = {4'h0, split_addr_ff};
                GOOD_SEGMENT_IDX:   nxt_rdata = {2'h0, good_seg_ff};
                BANK_CONFIG_IDX:    nxt_rdata = {o_bank_mode,bank_cfg_ff[5:0]};
                RECOVERY_BASE_IDX:  nxt_rdata = {cap.addr[7:2], 2'h0};
                8'hD5:              nxt_rdata = cap.addr[15:8];
                8'hD6:              nxt_rdata = cap.addr[23:16];
                8'hD7:              nxt_rdata = {1'b0, cap.addr[30:24]};
                8'hD8:              nxt_rdata = {cap_held, cap.mem_io,
                                                 cap.arb_grant, cap.arb_level,
                                                 cap.data_ctl};
                default: begin
                    if (i_reg_idx[7:2] == EXP_PAGE_BASE_IDX[7:2]) begin
                        nxt_rdata = page_all[9*tbl_idx +: 8];
                    end else if (i_reg_idx[7:2] ==
                                 BAD_BLOCK_BASE_IDX[7:2]) begin
                        nxt_rdata = bad_all[10*tbl_idx +: 8];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            split_control_ff  <= SPLIT_CONTROL_RST;
            shadow_control_ff <= SHADOW_CONTROL_RST;
            seg_lo_ff         <= 8'h00;
            seg_hi_ff         <= 8'h00;
            window_sel_ff     <= WINDOW_SELECT_RST;
            split_addr_ff     <= SPLIT_ADDRESS_RST[3:0];
            good_seg_ff       <= 6'h00;
            bank_cfg_ff       <= 8'h00;
            port61_ff         <= 8'h00;
            nmi_ff            <= 1'b0;
            rdata_ff          <= 8'h00;
        end else begin
            split_control_ff  <= nxt_split_control;
            shadow_control_ff <= nxt_shadow_control;
            seg_lo_ff         <= nxt_seg_lo;
            seg_hi_ff         <= nxt_seg_hi;
            window_sel_ff     <= nxt_window_sel;
            split_addr_ff     <= nxt_split_addr;
            good_seg_ff       <= nxt_good_seg;
            bank_cfg_ff       <= nxt_bank_cfg;
            port61_ff         <= nxt_port61;
            nmi_ff            <= nxt_nmi;
            rdata_ff          <= nxt_rdata;
        end
    end

    // ******
    // address translation, purely combinational per request
    // ******
    logic [23:0] a, pa;
    logic        hole, in_shadow, seg_on, rom_area, wprot;
    logic [15:0] seg_en;
    logic [3:0]  seg_idx;
    logic [23:0] win_base, split_lo, relo_base;
    logic        in_win, hit_relo;
    logic [1:0]  page;
    logic [23:0] relo_off;
    assign a        = i_req.addr[23:0];
    assign seg_en   = {seg_hi_ff, seg_lo_ff};
    assign seg_idx  = 4'(a[17:14] - SHADOW_LO[17:14]);
    assign split_lo = bound_512 ? ADDR_512K : ADDR_640K;
    assign relo_base = {split_addr_ff, 20'h00000};
    assign relo_off  = 24'(a - relo_base);
    // window base: index 4 means D0000, 0..3 step 16K from C0000
    assign win_base = window_sel_ff[2] ? 24'h0D0000 :
                      24'(WINDOW_C0 + {8'h00, window_sel_ff[1:0], 14'h0000});
    assign in_win   = exp_en && (a >= win_base) &&
                      (a < 24'(win_base + 24'h010000));
    assign page     = 2'(a[15:14] - win_base[15:14]);
    assign hole      = (a >= ADDR_640K) && (a < ADDR_1M);
    assign in_shadow = (a >= SHADOW_LO) && (a <= SHADOW_HI);
    assign seg_on    = in_shadow && seg_en[seg_idx] &&
                       shadow_control_ff[4] && shadow_control_ff[5];
    assign rom_area  = a >= ROM_LO;
    assign wprot     = seg_on && (a >= WPROT_LO) &&
                       shadow_control_ff[6] && shadow_control_ff[7];
    // relocated block: 384K for 512K split, 256K for 640K split
    assign hit_relo  = !split_off && (split_addr_ff != 4'h0) &&
                       (relo_off < 24'(ADDR_896K - split_lo));

    always_comb begin
        pa = a;
        if (in_win) begin
            pa = {1'b0, page_all[9*page +: 9], a[13:0]};
        end else if (hit_relo) begin
            pa = 24'(split_lo + relo_off);
        end
        // bad block slot redirect into the low 64K of the good 256K segment
        for (int k = 0; k < NUM_BAD; k++) begin
            if (bad_all[10*k+9] && bad_all[10*k +: 8] == pa[21:14]) begin
                pa = {good_seg_ff, 2'b00, k[1:0], pa[13:0]};
            end
        end
    end

    // rom select only for E0000-FFFFF while rom enable is set
    assign o_bios_rom_select_n = !(i_req.valid && i_req.mem_io &&
                                   rom_en && rom_area && (a < ADDR_1M));
    // hole usable where shadowed, in the window, or E0000+ with rom off; split hides 640K-896K
    assign o_ram_select = i_req.valid && i_req.mem_io &&
                          (!hole || in_win || seg_on ||
                           (rom_area && !rom_en));
    assign o_ram_write_en = o_ram_select && i_req.write && !wprot;
    assign o_phys_addr    = ADDR_W'(pa);
    assign o_reg_rdata    = rdata_ff;
    assign o_port61_rdata = port61_ff;
    assign o_nmi          = nmi_ff;

    // ******
    // bank mode: type bits per bank 0 none,1 256K,2 1M
    // mode 0 normal, 1 page only, 2 interleave pair, 3 pair+page
    // ******
    logic [1:0] t0, t1, t2, t3;
    assign t0 = bank_cfg_ff[1:0];
    assign t1 = bank_cfg_ff[3:2];
    assign t2 = bank_cfg_ff[5:4];
    assign t3 = bank_cfg_ff[7:6];
    always_comb begin
        o_bank_mode = 2'h0;
        if (t0 != 2'h0 && t1 == 2'h0) begin
            o_bank_mode = 2'h1;
        end else if (t0 == t1 && t0 != 2'h0) begin
            o_bank_mode = (t2 != 2'h0 && t3 == 2'h0) ? 2'h3 : 2'h2;
        end else if (t0 != 2'h0) begin
            o_bank_mode = 2'h1;
        end
    end
endmodule

/* verif/dams_top_props.sv */
// checker: control register mirrors, rom select, protect and parity
`timescale 1ns/100ps
module dams_top_props
    import dams_pkg::*;
(
    input wire logic       i_clock,
    input wire logic       i_rst_n,
    input wire logic       i_reg_wr,
    input wire logic       i_reg_rd,
    input wire logic [7:0] i_reg_idx,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire dams_req_s  i_req,
    input wire logic       i_parity_error,
    input wire logic       i_port61_wr,
    input wire logic [7:0] i_port61_wdata,
    input wire logic [7:0] o_port61_rdata,
    input wire logic       o_nmi,
    input wire logic       o_ram_write_en,
    input wire logic       o_bios_rom_select_n
);
    logic [7:0] split_ff, nxt_split, shad_ff, nxt_shad;
    logic [1:0] chk_ff, nxt_chk;
    logic       rom_area, prot_area, par_on, e1_wr;
    // ******
    // mirror of written control bits
    // ******
    assign e1_wr = i_reg_wr && i_reg_idx == SPLIT_CONTROL_IDX;
    always_comb begin
        nxt_split = e1_wr ? i_reg_wdata : split_ff;
        nxt_shad  = shad_ff;
        nxt_chk   = i_port61_wr ? i_port61_wdata[3:2] : chk_ff;
        if (i_reg_wr && i_reg_idx == SHADOW_CONTROL_IDX) begin
            nxt_shad = i_reg_wdata;
        end
    end
    // sync reset, same values the design comes out of reset with
    always_ff @(posedge i_clock) begin
        split_ff <= i_rst_n ? nxt_split : SPLIT_CONTROL_RST;
        shad_ff  <= i_rst_n ? nxt_shad : SHADOW_CONTROL_RST;
        chk_ff   <= i_rst_n ? nxt_chk : 2'b00;
    end
    assign rom_area = i_req.valid && i_req.mem_io && !i_req.write
        && i_req.addr[30:17] == 14'h0007;
    assign prot_area = i_req.valid && i_req.mem_io && i_req.write
        && i_req.addr[30:17] == 14'h0006;
    assign par_on = !split_ff[PARITY_DISABLE_BIT] && chk_ff == 2'b00;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    rom_off_a: assert property (
        rom_area && !split_ff[ROM_ENABLE_BIT] |-> o_bios_rom_select_n)
        else $error("rom selected while off");
    rom_on_a: assert property (
        rom_area && split_ff[ROM_ENABLE_BIT] |-> !o_bios_rom_select_n)
        else $error("rom not selected");
    split_rd_a: assert property (
        i_reg_rd && i_reg_idx == SPLIT_CONTROL_IDX
        |=> o_reg_rdata == $past(split_ff)) else $error("split readback");
    shad_rd_a: assert property (
        i_reg_rd && i_reg_idx == SHADOW_CONTROL_IDX
        |=> o_reg_rdata == $past(shad_ff)) else $error("shadow readback");
    write_prot_a: assert property (
        prot_area && shad_ff[7:6] == 2'b11 |-> !o_ram_write_en)
        else $error("protected write let through");
    nmi_set_a: assert property (
        i_parity_error && par_on |-> ##[1:2] o_port61_rdata[7] && o_nmi)
        else $error("parity error not flagged");
    par_off_a: assert property (
        i_parity_error && !par_on && !o_port61_rdata[7]
        |=> !o_port61_rdata[7]) else $error("flag while checks off");
    nmi_clr_a: assert property (
        e1_wr && i_reg_wdata[0] && !(i_parity_error && par_on)
        |-> ##[1:2] !o_port61_rdata[7] && !o_nmi) else $error("no clear");
    cover property (rom_area && !split_ff[ROM_ENABLE_BIT]);
    cover property (prot_area && shad_ff[7:6] == 2'b11);
    cover property (i_parity_error && par_on);
endmodule
bind dams_top dams_top_props u_props (.i_clock, .i_rst_n, .i_reg_wr,
    .i_reg_rd, .i_reg_idx, .i_reg_wdata, .o_reg_rdata, .i_req,
    .i_parity_error, .i_port61_wr, .i_port61_wdata, .o_port61_rdata,
    .o_nmi, .o_ram_write_en, .o_bios_rom_select_n);

/* verif/dams_host_model.sv */
// host side model: memory commands with arbitration and control lines
`timescale 1ns/100ps
module dams_host_model
    import dams_pkg::*;
(
    input  wire logic  i_clock,
    output dams_req_s  o_req,
    output logic [5:0] o_ctl,
    output logic       o_ext_map_n
);
    // internal mapper in use, so the board pin stays high
    initial begin
        o_req = '0;
        o_ctl = 6'h00;
        o_ext_map_n = 1'b1;
    end
    // command launched after an edge, held until replaced
    task automatic put(input logic [30:0] a, input logic w,
                       input logic [5:0] c);
        @(posedge i_clock);
        o_req <= '{valid: 1'b1, write: w, mem_io: 1'b1, addr: a};
        o_ctl <= c;
        #2;
    endtask
    // released bus shows the inverse, never a stale address
    task automatic drop();
        @(posedge i_clock);
        o_req <= '{valid: 1'b0, write: 1'b0, mem_io: 1'b0, addr: ~o_req.addr};
    endtask
endmodule

/* verif/dams_top_tb.sv */
// testbench: register access, mapping, shadow, parity and capture
`timescale 1ns/100ps
module dams_top_tb
    import dams_pkg::*;
;
    logic        i_clock = 1'b0, i_rst_n = 1'b0, i_reg_wr = 1'b0;
    logic        i_reg_rd = 1'b0, i_channel_error_n = 1'b1;
    logic        i_parity_error = 1'b0, i_port61_wr = 1'b0;
    logic [7:0]  i_reg_idx = 8'h00, i_reg_wdata = 8'h00;
    logic [7:0]  i_port61_wdata = 8'h00, o_reg_rdata, o_port61_rdata;
    logic [23:0] o_phys_addr;
    logic        o_nmi, o_ram_select, o_ram_write_en, o_bios_rom_select_n;
    logic        i_external_mapper_select_n;
    logic [5:0]  ctl;
    dams_req_s   i_req;
    int          failures = 0, n_tests = 0;
    always #12.5 i_clock = ~i_clock;
    dams_top DUT (.i_clock, .i_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_idx,
        .i_reg_wdata, .o_reg_rdata, .i_req, .i_arb_grant_phase(ctl[5]),
        .i_arbitration_level_lines(ctl[4:1]), .i_data_ctl(ctl[0]),
        .i_channel_error_n, .i_external_mapper_select_n, .i_parity_error,
        .i_port61_wr, .i_port61_wdata, .o_port61_rdata, .o_nmi, .o_phys_addr,
        .o_ram_select, .o_ram_write_en, .o_bios_rom_select_n, .o_bank_mode());
    dams_host_model host (.i_clock, .o_req(i_req), .o_ctl(ctl),
        .o_ext_map_n(i_external_mapper_select_n));
    // ******
    // access and compare tasks
    // ******
    task automatic chk(input logic [23:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] idx, d, input logic p61 = 1'b0);
        @(posedge i_clock);
        {i_reg_wr, i_port61_wr} <= {!p61, p61};
        {i_reg_idx, i_reg_wdata, i_port61_wdata} <= {idx, d, d};
        @(posedge i_clock);
        {i_reg_wr, i_port61_wr} <= 2'b00;
        #2;
    endtask
    task automatic rd(input logic [7:0] idx, exp);
        @(posedge i_clock);
        i_reg_rd <= 1'b1;
        i_reg_idx <= idx;
        @(posedge i_clock);
        i_reg_rd <= 1'b0;
        #2 chk({16'h0000, o_reg_rdata}, {16'h0000, exp});
    endtask
    // one-cycle error pulse, flag and nmi land later
    task automatic par(input logic exp);
        @(posedge i_clock);
        i_parity_error <= 1'b1;
        @(posedge i_clock);
        i_parity_error <= 1'b0;
        repeat (2) @(posedge i_clock);
        #2 chk({23'h0, o_nmi}, {23'h0, exp});
    endtask
    task automatic print_verdict();
        if (failures == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // whole sequence is under 120 cycles
    initial begin
        #(25 * 5000);
        failures++;
        print_verdict();
    end
    initial begin
        repeat (20) @(posedge i_clock);
        i_rst_n <= 1'b1;
        rd(SPLIT_CONTROL_IDX, SPLIT_CONTROL_RST);
        rd(SHADOW_CONTROL_IDX, SHADOW_CONTROL_RST);
        rd(8'h00, 8'h00);
        host.put(31'h0E0000, 1'b0, 6'h00);
        chk({23'h0, o_bios_rom_select_n}, 24'h0);
        wr(SPLIT_CONTROL_IDX, 8'h08);
        rd(SPLIT_CONTROL_IDX, 8'h08);
        host.put(31'h0E0000, 1'b0, 6'h00);
        chk({22'h0, o_bios_rom_select_n, o_ram_select}, 24'h3);
        wr(SHADOW_CONTROL_IDX, 8'h30);
        wr(SEG_ENABLE_HI_IDX, 8'hFF);
        host.put(31'h0DC000, 1'b0, 6'h00);
        chk({23'h0, o_ram_select}, 24'h1);
        wr(SEG_ENABLE_HI_IDX, 8'h7F);
        chk({23'h0, o_ram_select}, 24'h0);
        wr(SHADOW_CONTROL_IDX, 8'hF0);
        host.put(31'h0C0000, 1'b1, 6'h00);
        chk({23'h0, o_ram_write_en}, 24'h0);
        wr(SHADOW_CONTROL_IDX, 8'h00);
        wr(WINDOW_SELECT_IDX, 8'h84);
        for (int n = 0; n < NUM_PAGES; n++) begin
            wr(EXP_PAGE_BASE_IDX + 8'(n), 8'h40 + 8'(n));
            host.put(31'h0D0123 + 31'(n * 'h4000), 1'b0, 6'h00);
            chk(o_phys_addr, 24'h100123 + 24'(n * 'h4000));
        end
        wr(WINDOW_SELECT_IDX, 8'h81);
        host.put(31'h0C4010, 1'b0, 6'h00);
        chk(o_phys_addr, 24'h100010);
        wr(SPLIT_ADDRESS_IDX, 8'h02);
        wr(SPLIT_CONTROL_IDX, 8'h00);
        host.put(31'h200010, 1'b0, 6'h00);
        chk(o_phys_addr, 24'h0A0010);
        host.put(31'h240010, 1'b0, 6'h00);
        chk(o_phys_addr, 24'h240010);
        wr(SPLIT_CONTROL_IDX, 8'h04);
        chk(o_phys_addr, 24'h0C0010);
        wr(SPLIT_CONTROL_IDX, 8'h0C);
        wr(BAD_BLOCK_BASE_IDX, 8'h81);
        wr(GOOD_SEGMENT_IDX, 8'h05);
        host.put(31'h204010, 1'b0, 6'h00);
        chk(o_phys_addr, 24'h140010);
        wr(BANK_CONFIG_IDX, 8'h01);
        rd(BANK_CONFIG_IDX, 8'h41);
        wr(BANK_CONFIG_IDX, 8'h15);
        rd(BANK_CONFIG_IDX, 8'hD5);
        par(1'b1);
        wr(SPLIT_CONTROL_IDX, 8'h09);
        wr(8'h00, 8'h0C, 1'b1);
        par(1'b0);
        wr(SPLIT_CONTROL_IDX, 8'h08);
        par(1'b0);
        wr(8'h00, 8'h00, 1'b1);
        par(1'b1);
        host.put(31'h12345678, 1'b0, 6'h2B);
        host.drop();
        @(posedge i_clock);
        i_channel_error_n <= 1'b0;
        rd(RECOVERY_BASE_IDX + 8'h04, 8'hEB);
        rd(RECOVERY_BASE_IDX + 8'h02, 8'h34);
        print_verdict();
    end
endmodule
